// [src/ift_ctrl.sv]
// I2C controller slice: FIFO thresholds, level flags, read-to-clear flags.
// Assumes a simple synchronous register port and FIFO levels from the
// surrounding controller, all on mclk.
//
// Overview of operation
// - Receive threshold, five bits, read/write, resets zero
// - Receive value N triggers at N+1 entries
// - Oversized threshold write stores 31, one below the depth
// - Transmit threshold, five bits, read/write, resets zero
// - Transmit value maps directly to entries
// - Combined clear read drops all software flags
// - Combined clear leaves level flags alone
// - Abort-source clear honours the bit 9 exception
// - Underflow clear read drops bit 0
// - Receive-overflow clear read drops bit 1
// - Transmit-overflow clear read drops bit 3
// - Read-request clear read drops bit 5
// - Receive-level flag follows level above threshold
// - Transmit-level flag follows level at/below threshold
// - Hold clock low until read serviced
`timescale 1ns/1ps
module ift_ctrl (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         sys_rst,
    // Register port
    input  wire logic [ift_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic                         reg_rd,
    input  wire logic                         reg_wr,
    input  wire logic [ift_pkg::DATA_W-1:0]   reg_wdata,
    output logic      [ift_pkg::DATA_W-1:0]   reg_rdata,
    // FIFO levels and raw events from the controller
    input  wire logic [ift_pkg::LVL_W-1:0]    rx_level,
    input  wire logic [ift_pkg::LVL_W-1:0]    tx_level,
    input  wire logic                         rx_under_evt,
    input  wire logic                         rx_over_evt,
    input  wire logic                         tx_over_evt,
    input  wire logic                         rd_req_evt,
    input  wire logic                         tx_data_written,
    input  wire logic                         abrt_keep,
    // Raw flags and side effects
    output logic      [5:0]                   raw_interrupt_status,
    output logic                              abort_source_clear,
    output logic                              combined_clear_pulse,
    output logic                              scl_hold
);

    // Threshold fields
    logic [4:0]  rx_thr_q;
    logic [4:0]  tx_thr_q;
    logic [4:0]  wdata_clamped;

    // Software-cleared flags
    logic        rx_under_q;
    logic        rx_over_q;
    logic        tx_over_q;
    logic        rd_req_q;

    // Hardware-cleared level flags
    logic        rx_full_q;
    logic        tx_empty_q;
    logic [5:0]  rx_trigger;
    logic [5:0]  tx_trigger;
    logic        rx_at_level;
    logic        tx_at_level;

    // Decoded register accesses
    logic        rd_all;
    logic        rd_rxu;
    logic        rd_rxo;
    logic        rd_txo;
    logic        rd_rrq;
    logic        rd_rx;
    logic        rd_tx;
    logic        wr_rx;
    logic        wr_tx;

    // Clear conditions per flag
    logic        clr_rxu;
    logic        clr_rxo;
    logic        clr_txo;
    logic        clr_rrq;

    // Next values
    logic [15:0] rdata_d;
    logic [5:0]  raw_d;
    logic        hold_d;
    logic        abort_d;

    // Clamp a written threshold to TL_MAX, one below the buffer depth
    function automatic logic [4:0] clamp_tl(input logic [15:0] v);
        if (v > 16'(ift_pkg::TL_MAX)) begin
            clamp_tl = ift_pkg::TL_MAX;
        end else begin
            clamp_tl = v[4:0];
        end
    endfunction

    // One strobe meeting one register address
    function automatic logic hit(input logic strobe, input logic [31:0] addr, input logic [31:0] target);
        hit = strobe && (addr == target);
    endfunction

    // Event sets, clear read drops, a new event wins a tie
    function automatic logic next_flag(input logic cur, input logic set, input logic clr);
        if (set) begin
            next_flag = 1'b1;
        end else if (clr) begin
            next_flag = 1'b0;
        end else begin
            next_flag = cur;
        end
    endfunction

    // Only reads clear; writes reach the thresholds alone
    assign rd_all = hit(reg_rd, reg_addr, ift_pkg::ADDR_CLR_ALL);
    assign rd_rxu = hit(reg_rd, reg_addr, ift_pkg::ADDR_CLR_RXU);
    assign rd_rxo = hit(reg_rd, reg_addr, ift_pkg::ADDR_CLR_RXO);
    assign rd_txo = hit(reg_rd, reg_addr, ift_pkg::ADDR_CLR_TXO);
    assign rd_rrq = hit(reg_rd, reg_addr, ift_pkg::ADDR_CLR_RRQ);
    assign rd_rx  = hit(reg_rd, reg_addr, ift_pkg::ADDR_RX_THR);
    assign rd_tx  = hit(reg_rd, reg_addr, ift_pkg::ADDR_TX_THR);
    assign wr_rx  = hit(reg_wr, reg_addr, ift_pkg::ADDR_RX_THR);
    assign wr_tx  = hit(reg_wr, reg_addr, ift_pkg::ADDR_TX_THR);

    // The combined read drops every software flag
    assign clr_rxu = rd_rxu || rd_all;
    assign clr_rxo = rd_rxo || rd_all;
    assign clr_txo = rd_txo || rd_all;
    assign clr_rrq = rd_rrq || rd_all;

    assign wdata_clamped = clamp_tl(reg_wdata);
    assign rx_trigger    = {1'b0, rx_thr_q} + 6'h01;
    assign tx_trigger    = {1'b0, tx_thr_q};
    assign rx_at_level   = rx_level >= rx_trigger;
    assign tx_at_level   = tx_level <= tx_trigger;

    // Receive threshold
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_thr_q <= ift_pkg::TL_RESET;
        end else if (wr_rx) begin
            rx_thr_q <= wdata_clamped;
        end
    end

    // Transmit threshold
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_thr_q <= ift_pkg::TL_RESET;
        end else if (wr_tx) begin
            tx_thr_q <= wdata_clamped;
        end
    end

    // Read mux; single clear registers read back their flag, the combined one any raw flag
    always_comb begin
        rdata_d = 16'h0000;
        if (rd_rx) begin
            rdata_d = {11'h000, rx_thr_q};
        end else if (rd_tx) begin
            rdata_d = {11'h000, tx_thr_q};
        end else if (rd_all) begin
            rdata_d = {15'h0000, |raw_interrupt_status};
        end else if (rd_rxu) begin
            rdata_d = {15'h0000, rx_under_q};
        end else if (rd_rxo) begin
            rdata_d = {15'h0000, rx_over_q};
        end else if (rd_txo) begin
            rdata_d = {15'h0000, tx_over_q};
        end else if (rd_rrq) begin
            rdata_d = {15'h0000, rd_req_q};
        end
    end

    // Read data holds until the next read
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end

    // Receive underflow flag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_under_q <= 1'b0;
        end else begin
            rx_under_q <= next_flag(rx_under_q, rx_under_evt, clr_rxu);
        end
    end

    // Receive overflow flag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_over_q <= 1'b0;
        end else begin
            rx_over_q <= next_flag(rx_over_q, rx_over_evt, clr_rxo);
        end
    end

    // Transmit overflow flag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_over_q <= 1'b0;
        end else begin
            tx_over_q <= next_flag(tx_over_q, tx_over_evt, clr_txo);
        end
    end

    // Read request flag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_req_q <= 1'b0;
        end else begin
            rd_req_q <= next_flag(rd_req_q, rd_req_evt, clr_rrq);
        end
    end

    // Receive level flag follows the FIFO, never a clear read
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_full_q <= 1'b0;
        end else begin
            rx_full_q <= rx_at_level;
        end
    end

    // Transmit level flag follows the FIFO, never a clear read
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_empty_q <= 1'b0;
        end else begin
            tx_empty_q <= tx_at_level;
        end
    end

    // Abort-source clear, suppressed while the keep bit holds
    assign abort_d = rd_all && !abrt_keep;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            abort_source_clear <= 1'b0;
        end else begin
            abort_source_clear <= abort_d;
        end
    end

    // Combined clear pulse
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            combined_clear_pulse <= 1'b0;
        end else begin
            combined_clear_pulse <= rd_all;
        end
    end

    // Clock stretch: a read request holds, reply data frees
    always_comb begin
        hold_d = scl_hold;
        if (rd_req_evt) begin
            hold_d = 1'b1;
        end else if (tx_data_written) begin
            hold_d = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_hold <= 1'b0;
        end else begin
            scl_hold <= hold_d;
        end
    end

    // Raw status assembled at the documented bit positions
    always_comb begin
        raw_d                        = 6'h00;
        raw_d[ift_pkg::BIT_RX_UNDER] = rx_under_q;
        raw_d[ift_pkg::BIT_RX_OVER]  = rx_over_q;
        raw_d[ift_pkg::BIT_RX_FULL]  = rx_full_q;
        raw_d[ift_pkg::BIT_TX_OVER]  = tx_over_q;
        raw_d[ift_pkg::BIT_TX_EMPTY] = tx_empty_q;
        raw_d[ift_pkg::BIT_RD_REQ]   = rd_req_q;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            raw_interrupt_status <= 6'h00;
        end else begin
            raw_interrupt_status <= raw_d;
        end
    end

endmodule

// [shared/ift_pkg.sv]
// Package for the I2C threshold and read-to-clear block.
// Assumes a 32-deep receive and transmit FIFO and a 16-bit register bus.
package ift_pkg;
    localparam int          DATA_W       = 16;
    localparam int          ADDR_W       = 32;
    localparam int          LVL_W        = 6;
    localparam int          TL_W         = 5;
    localparam logic [5:0]  FIFO_DEPTH   = 6'h20;
    localparam logic [4:0]  TL_MAX       = 5'h1f;
    localparam logic [4:0]  TL_RESET     = 5'h00;
    // Register byte addresses
    localparam logic [31:0] ADDR_RX_THR  = 32'h50001438;
    localparam logic [31:0] ADDR_TX_THR  = 32'h5000143c;
    localparam logic [31:0] ADDR_CLR_ALL = 32'h50001440;
    localparam logic [31:0] ADDR_CLR_RXU = 32'h50001444;
    localparam logic [31:0] ADDR_CLR_RXO = 32'h50001448;
    localparam logic [31:0] ADDR_CLR_TXO = 32'h5000144c;
    localparam logic [31:0] ADDR_CLR_RRQ = 32'h50001450;
    // Raw status bit positions
    localparam int          BIT_RX_UNDER = 0;
    localparam int          BIT_RX_OVER  = 1;
    localparam int          BIT_RX_FULL  = 2;
    localparam int          BIT_TX_OVER  = 3;
    localparam int          BIT_TX_EMPTY = 4;
    localparam int          BIT_RD_REQ   = 5;
    localparam int          ABRT_KEEP    = 9;
endpackage

// [verification/ift_ctrl_assertions.sv]
// Checker for the threshold and read-to-clear slice.
// Assumes a bind onto ift_ctrl; sees its ports only.
`timescale 1ns/1ps
module ift_ctrl_assertions (
    input wire logic                       mclk, sys_rst, reg_rd, rx_under_evt, rd_req_evt,
    input wire logic                       tx_data_written, abrt_keep, abort_source_clear,
    input wire logic                       combined_clear_pulse, scl_hold,
    input wire logic [ift_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ift_pkg::LVL_W-1:0]  rx_level, tx_level,
    input wire logic [5:0]                 raw_interrupt_status
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire rd_all = reg_rd && reg_addr == ift_pkg::ADDR_CLR_ALL;
    AST_RXU_CLR: assert property (reg_rd && reg_addr == ift_pkg::ADDR_CLR_RXU && !rx_under_evt ##1 !rx_under_evt
        |-> ##1 !raw_interrupt_status[0]) else $error("underflow flag survived its clear");
    AST_RRQ_CLR: assert property (reg_rd && reg_addr == ift_pkg::ADDR_CLR_RRQ && !rd_req_evt ##1 !rd_req_evt
        |-> ##1 !raw_interrupt_status[5]) else $error("read request flag survived its clear");
    AST_ALL_PULSE: assert property (rd_all |=> combined_clear_pulse)
        else $error("combined clear pulse missing");
    AST_ABRT_CLR: assert property (rd_all |=> abort_source_clear == !$past(abrt_keep))
        else $error("abort source clear wrong");
    AST_NO_PULSE: assert property (!reg_rd |=> !combined_clear_pulse)
        else $error("clear pulse without a read");
    AST_HOLD: assert property (rd_req_evt |=> scl_hold)
        else $error("clock not held after read request");
    AST_RELEASE: assert property (tx_data_written && !rd_req_evt |=> !scl_hold)
        else $error("clock still held after reply data");
    AST_RX_LVL: assert property ((rx_level == 6'h00) [*3] |-> !raw_interrupt_status[2])
        else $error("receive level flag set on empty fifo");
    AST_TX_LVL: assert property ((tx_level == 6'h00) [*3] |-> raw_interrupt_status[4])
        else $error("transmit level flag clear on empty fifo");
    COV_ALL: cover property (rd_all ##1 abort_source_clear);
    COV_HOLD: cover property (scl_hold ##1 !scl_hold);
    COV_RX: cover property (raw_interrupt_status[2]);
endmodule

// [verification/ift_ctrl_tb_top.sv]
// Testbench for ift_ctrl: thresholds, level flags, read-to-clear.
// Assumes the checker file is compiled alongside.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; $display("Error at %0t: %h vs %h", $time, a, e); end end
module ift_ctrl_tb_top;
    logic        mclk = 1'b0, sys_rst = 1'b1, reg_rd = 1'b0, reg_wr = 1'b0, abrt_keep = 1'b0, tx_data_written = 1'b0;
    logic        rx_under_evt = 1'b0, rx_over_evt = 1'b0, tx_over_evt = 1'b0, rd_req_evt = 1'b0;
    logic [31:0] reg_addr = 32'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata, rd_v;
    logic [5:0]  rx_level = 6'h00, tx_level = 6'h00, raw_interrupt_status;
    logic        abort_source_clear, combined_clear_pulse, scl_hold;
    int          n_mismatch = 0, n_tests = 0, cyc = 0;
    ift_ctrl DUT (.mclk, .sys_rst, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .rx_level, .tx_level,
        .rx_under_evt, .rx_over_evt, .tx_over_evt, .rd_req_evt, .tx_data_written, .abrt_keep,
        .raw_interrupt_status, .abort_source_clear, .combined_clear_pulse, .scl_hold);
    always #4 mclk = ~mclk;
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(logic [31:0] a, logic [15:0] d);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        tick(1);
        reg_wr = 1'b0;
    endtask
    task automatic rd(logic [31:0] a);
        {reg_rd, reg_addr} = {1'b1, a};
        tick(1);
        reg_rd = 1'b0;
        rd_v = reg_rdata;
    endtask
    task automatic pulse(int b);
        {rd_req_evt, tx_over_evt, rx_over_evt, rx_under_evt} = 4'h1 << b;
        tick(1);
        {rd_req_evt, tx_over_evt, rx_over_evt, rx_under_evt} = 4'h0;
    endtask
    task automatic t_thr;
        rd(ift_pkg::ADDR_RX_THR); `CHK(rd_v, 16'h0000)
        rd(ift_pkg::ADDR_TX_THR); `CHK(rd_v, 16'h0000)
        rd(32'h50001460); `CHK(rd_v, 16'h0000)
        wr(ift_pkg::ADDR_RX_THR, 16'h0020); rd(ift_pkg::ADDR_RX_THR); `CHK(rd_v, 16'h001f)
        wr(ift_pkg::ADDR_RX_THR, 16'h0007); rx_level = 6'h07; tick(4);
        `CHK(raw_interrupt_status[2], 1'b0)
        rx_level = 6'h08; tick(3); `CHK(raw_interrupt_status[2], 1'b1)
        wr(ift_pkg::ADDR_TX_THR, 16'h0005); tx_level = 6'h05; tick(4);
        `CHK(raw_interrupt_status[4], 1'b1)
        tx_level = 6'h06; tick(3); `CHK(raw_interrupt_status[4], 1'b0)
    endtask
    task automatic t_clr;
        logic [31:0] ca [4] = '{ift_pkg::ADDR_CLR_RXU, ift_pkg::ADDR_CLR_RXO, ift_pkg::ADDR_CLR_TXO, ift_pkg::ADDR_CLR_RRQ};
        int          bp [4] = '{0, 1, 3, 5};
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            wr(ca[i], 16'hffff);
            tick(2);
            `CHK(raw_interrupt_status[bp[i]], 1'b1)
            rd(ca[i]);
            `CHK(rd_v, 16'h0001)
            tick(1);
            `CHK(raw_interrupt_status[bp[i]], 1'b0)
        end
    endtask
    task automatic t_all(logic k);
        {abrt_keep, rx_level, tx_level} = {k, 6'h20, 6'h20};
        {rd_req_evt, tx_over_evt, rx_over_evt, rx_under_evt} = 4'hf;
        tick(1);
        {rd_req_evt, tx_over_evt, rx_over_evt, rx_under_evt} = 4'h0;
        tick(2);
        `CHK(scl_hold, 1'b1)
        rd(ift_pkg::ADDR_CLR_ALL);
        `CHK({combined_clear_pulse, abort_source_clear}, {1'b1, ~k})
        tick(1);
        `CHK(raw_interrupt_status, 6'h04)
        tx_data_written = 1'b1;
        tick(1);
        tx_data_written = 1'b0;
        tick(1);
        `CHK(scl_hold, 1'b0)
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            give_verdict;
        end
    end
    initial begin
        tick(20);
        sys_rst = 1'b0;
        tick(1);
        t_thr;
        t_clr;
        t_all(1'b1);
        t_all(1'b0);
        give_verdict;
    end
endmodule
bind ift_ctrl ift_ctrl_assertions u_chk (.mclk, .sys_rst, .reg_rd, .rx_under_evt, .rd_req_evt, .tx_data_written,
    .abrt_keep, .abort_source_clear, .combined_clear_pulse, .scl_hold, .reg_addr, .rx_level, .tx_level,
    .raw_interrupt_status);
